// >>> design/htc_trap_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - status holds sie 1, mie 3, saved enables 5/7, spp 8, mpp 12:11
// - enable register holds soft 1/3, timer 5/7, external 9/11 enables
// - local interrupt n enable sits at bit 16+n, up to bit 63
// - machine pending 3/7/11 read-only; supervisor pending 1/5/9 writable
// - local pending bits 16..63 are read-only copies of the lines
// - every machine trap writes cause; bit 63 marks interrupts
// - interrupt cause code equals the pending bit position of source
// - exception codes 0..9, 11, 12, 13, 15 are the legal set
// - vector mode field in bits 1:0; 0 direct, 1 vectored, rest reserved
// - direct mode jumps every trap to the vector base
// - vectored mode jumps interrupts to base plus four times cause
// - machine external interrupt reports cause 11
// - interrupt delegation implements only bits 1, 5 and 9
// - exception delegation implements codes 0..9, 12, 13, 15 only
// - delegated trap copies cause and pc to supervisor, jumps to stvec
// - local interrupts are never delegated
// - machine software may write supervisor pending bits directly
// - supervisor status is a masked view sharing machine status bits
// - interrupt entry saves enable, clears it, saves pc and privilege
// - trap return restores privilege, enable and pc
// - priority: local 47..0, m ext, m soft, m timer, s ext, s soft, s timer
module htc_trap_unit
	import htc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire htc_apb_req_s apb_req,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic [47:0] local_irq,
	input wire logic machine_soft_irq_flag,
	input wire logic machine_timer_irq_flag,
	input wire logic machine_external_irq_flag,
	input wire htc_core_req_s core_req,
	output htc_core_rsp_s core_rsp,
	output logic [1:0] irq_taken
);
	logic [63:0] mstatus_q, mie_q, mip_sw, mcause_q, mtvec_q;
	logic [63:0] mideleg_q, medeleg_q, mepc_q, scause_q, sepc_q, stvec_q;
	logic [1:0] priv_q;
	logic [47:0] loc_s1, loc_s2;
	logic [2:0] mx_s1, mx_s2;

	// pin lines pass two flops before use
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			loc_s1 <= '0;
			loc_s2 <= '0;
			mx_s1 <= '0;
			mx_s2 <= '0;
		end
		else
		begin
			loc_s1 <= local_irq;
			loc_s2 <= loc_s1;
			mx_s1 <= {machine_external_irq_flag, machine_timer_irq_flag,
				machine_soft_irq_flag};
			mx_s2 <= mx_s1;
		end
	end

	// pending view: hardware bits read-only
	wire [63:0] mip_view = {loc_s2, 4'h0, mx_s2[2], 3'h0, mx_s2[1], 3'h0,
		mx_s2[0], 3'h0} | mip_sw;
	wire [63:0] active = mip_view & mie_q;

	wire m_glob_on = mstatus_q[ST_MIE] | (priv_q != PRIV_M);
	wire s_glob_on = (priv_q == PRIV_U) |
		((priv_q == PRIV_S) & mstatus_q[ST_SIE]);
	// local bits never in mideleg mask, so always machine level
	wire [63:0] m_act = active & ~mideleg_q & {64{m_glob_on}};
	wire [63:0] s_act = active & mideleg_q & {64{s_glob_on}} &
		{64{priv_q != PRIV_M}};

	// fixed priority pick, returns cause code and hit
	function automatic logic [6:0] pick(input logic [63:0] m,
		input logic [63:0] s);
		logic [6:0] r;
		r = '0;
		if (s[IRQ_ST])
			r = {1'b1, 6'(IRQ_ST)};
		if (s[IRQ_SS])
			r = {1'b1, 6'(IRQ_SS)};
		if (s[IRQ_SE])
			r = {1'b1, 6'(IRQ_SE)};
		if (m[IRQ_MT])
			r = {1'b1, 6'(IRQ_MT)};
		if (m[IRQ_MS])
			r = {1'b1, 6'(IRQ_MS)};
		if (m[IRQ_ME])
			r = {1'b1, 6'(IRQ_ME)};
		for (int i = LOCAL_BASE; i < 64; i++)
			if (m[i])
				r = {1'b1, 6'(i)};
		return r;
	endfunction

	wire [6:0] sel = pick(m_act, s_act);
	wire irq_hit = sel[6];
	wire [5:0] irq_code = sel[5:0];
	wire irq_deleg = irq_hit & mideleg_q[irq_code];
	wire exc_legal = EXC_LEGAL[core_req.exc_code];
	wire exc_take = core_req.exc_valid & exc_legal;
	wire trap = irq_hit | exc_take;
	wire is_irq = irq_hit;
	wire [5:0] code = is_irq ? irq_code : {2'h0, core_req.exc_code};
	wire deleg = is_irq ? irq_deleg :
		(medeleg_q[code] & (priv_q != PRIV_M));
	wire [63:0] cause_val = {is_irq, 57'h0, code};
	wire [63:0] tvec = deleg ? stvec_q : mtvec_q;
	wire [63:0] tbase = {tvec[63:2], 2'h0};
	wire [63:0] vec_off = {56'h0, code, 2'h0};
	wire [63:0] trap_pc = (is_irq && tvec[1:0] == MODE_VECTORED) ?
		tbase + vec_off : tbase;

	// apb decode
	wire acc = apb_req.psel & apb_req.penable;
	wire wr = acc & apb_req.pwrite;
	wire [7:0] a = apb_req.paddr;
	wire [31:0] wd = apb_req.pwdata;
	wire hi = a[2];
	function automatic logic [63:0] merge(input logic [63:0] old,
		input logic [31:0] d, input logic h, input logic [63:0] msk);
		logic [63:0] n;
		n = h ? {d, old[31:0]} : {old[63:32], d};
		return (old & ~msk) | (n & msk);
	endfunction
	wire hit_mst = a[7:3] == ADDR_MSTATUS_LO[7:3];
	wire hit_sst = a[7:3] == ADDR_SSTATUS_LO[7:3];
	wire [63:0] st_wr = hit_sst ? merge(mstatus_q, wd, hi, SSTATUS_MASK) :
		merge(mstatus_q, wd, hi, MSTATUS_MASK);

	logic [63:0] rd64;
	logic mapped;
	always_comb
	begin
		rd64 = '0;
		mapped = 1'b1;
		unique case (a[7:3])
			ADDR_MSTATUS_LO[7:3]: rd64 = mstatus_q;
			ADDR_MIE_LO[7:3]: rd64 = mie_q;
			ADDR_MIP_LO[7:3]: rd64 = mip_view;
			ADDR_MCAUSE_LO[7:3]: rd64 = mcause_q;
			ADDR_MTVEC_LO[7:3]: rd64 = mtvec_q;
			ADDR_MIDELEG_LO[7:3]: rd64 = mideleg_q;
			ADDR_MEDELEG_LO[7:3]: rd64 = medeleg_q;
			ADDR_SSTATUS_LO[7:3]: rd64 = mstatus_q & SSTATUS_MASK;
			ADDR_SCAUSE_LO[7:3]: rd64 = scause_q;
			ADDR_SEPC_LO[7:3]: rd64 = sepc_q;
			ADDR_MEPC_LO[7:3]: rd64 = mepc_q;
			ADDR_STVEC_LO[7:3]: rd64 = stvec_q;
			ADDR_PRIV[7:3]: rd64 = {62'h0, priv_q};
			default: mapped = 1'b0;
		endcase
	end

	// bus writes act only when no trap or return updates the same cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			mstatus_q <= RST_ZERO;
			mie_q <= RST_ZERO;
			mip_sw <= RST_ZERO;
			mcause_q <= RST_ZERO;
			mtvec_q <= RST_ZERO;
			mideleg_q <= RST_ZERO;
			medeleg_q <= RST_ZERO;
			mepc_q <= RST_ZERO;
			scause_q <= RST_ZERO;
			sepc_q <= RST_ZERO;
			stvec_q <= RST_ZERO;
			priv_q <= RST_PRIV;
		end
		else if (trap && deleg)
		begin
			scause_q <= cause_val;
			sepc_q <= core_req.pc;
			mstatus_q[ST_SUPERVISOR_SAVED_IRQ_ON] <= mstatus_q[ST_SIE];
			mstatus_q[ST_SIE] <= 1'b0;
			mstatus_q[ST_SPP] <= priv_q[0];
			priv_q <= PRIV_S;
		end
		else if (trap)
		begin
			mcause_q <= cause_val;
			mepc_q <= core_req.pc;
			mstatus_q[ST_MACHINE_SAVED_IRQ_ON] <= mstatus_q[ST_MIE];
			mstatus_q[ST_MIE] <= 1'b0;
			mstatus_q[ST_MPP_HI:ST_MPP_LO] <= priv_q;
			priv_q <= PRIV_M;
		end
		else if (core_req.ret_valid)
		begin
			priv_q <= mstatus_q[ST_MPP_HI:ST_MPP_LO];
			mstatus_q[ST_MIE] <= mstatus_q[ST_MACHINE_SAVED_IRQ_ON];
			mstatus_q[ST_MACHINE_SAVED_IRQ_ON] <= 1'b1;
			mstatus_q[ST_MPP_HI:ST_MPP_LO] <= PRIV_U;
		end
		else if (wr)
		begin
			if (hit_mst || hit_sst)
				mstatus_q <= st_wr;
			if (a[7:3] == ADDR_MIE_LO[7:3])
				mie_q <= merge(mie_q, wd, hi, MIE_MASK);
			if (a[7:3] == ADDR_MIP_LO[7:3])
				mip_sw <= merge(mip_sw, wd, hi, MIP_SW_MASK);
			if (a[7:3] == ADDR_MCAUSE_LO[7:3])
				mcause_q <= merge(mcause_q, wd, hi, '1);
			if (a[7:3] == ADDR_MTVEC_LO[7:3])
				mtvec_q <= merge(mtvec_q, wd, hi, '1);
			if (a[7:3] == ADDR_MIDELEG_LO[7:3])
				mideleg_q <= merge(mideleg_q, wd, hi, MIDELEG_MASK);
			if (a[7:3] == ADDR_MEDELEG_LO[7:3])
				medeleg_q <= merge(medeleg_q, wd, hi, MEDELEG_MASK);
			if (a[7:3] == ADDR_SCAUSE_LO[7:3])
				scause_q <= merge(scause_q, wd, hi, '1);
			if (a[7:3] == ADDR_SEPC_LO[7:3])
				sepc_q <= merge(sepc_q, wd, hi, '1);
			if (a[7:3] == ADDR_MEPC_LO[7:3])
				mepc_q <= merge(mepc_q, wd, hi, '1);
			if (a[7:3] == ADDR_STVEC_LO[7:3])
				stvec_q <= merge(stvec_q, wd, hi, '1);
		end
	end

	// registered outputs; zero-wait apb, answer one cycle after setup
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			core_rsp <= '0;
			irq_taken <= '0;
		end
		else
		begin
			pready <= apb_req.psel & ~apb_req.penable;
			pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
			prdata <= hi ? rd64[63:32] : rd64[31:0];
			core_rsp.redirect <= trap | core_req.ret_valid;
			core_rsp.target <= trap ? trap_pc : mepc_q;
			core_rsp.priv <= trap ? (deleg ? PRIV_S : PRIV_M) :
				(core_req.ret_valid ? mstatus_q[ST_MPP_HI:ST_MPP_LO] :
				priv_q);
			irq_taken <= {irq_hit & ~irq_deleg, irq_hit & irq_deleg};
		end
	end

	a_cause_irq_bit: assert property (@(posedge mclk) disable iff (rst)
		(irq_hit && !irq_deleg) |=> mcause_q[CAUSE_IRQ_BIT])
		else $error("cause interrupt bit not set");
	a_mie_cleared: assert property (@(posedge mclk) disable iff (rst)
		(trap && !deleg) |=> !mstatus_q[ST_MIE] && priv_q == PRIV_M)
		else $error("machine enable not cleared on trap");
	a_saved_enable: assert property (@(posedge mclk) disable iff (rst)
		(trap && !deleg) |=> mstatus_q[ST_MACHINE_SAVED_IRQ_ON] == $past(mstatus_q[ST_MIE]))
		else $error("saved enable wrong");
	a_ret_restore: assert property (@(posedge mclk) disable iff (rst)
		(core_req.ret_valid && !trap) |=>
		priv_q == $past(mstatus_q[ST_MPP_HI:ST_MPP_LO]) &&
		core_rsp.target == $past(mepc_q))
		else $error("return did not restore state");
	a_vector_target: assert property (@(posedge mclk) disable iff (rst)
		(irq_hit && !irq_deleg && mtvec_q[1:0] == MODE_VECTORED) |=>
		core_rsp.target == {$past(mtvec_q[63:2]), 2'h0} +
		{56'h0, $past(irq_code), 2'h0})
		else $error("vectored target wrong");
	a_direct_target: assert property (@(posedge mclk) disable iff (rst)
		(trap && !deleg && mtvec_q[1:0] == MODE_DIRECT) |=>
		core_rsp.target == {$past(mtvec_q[63:2]), 2'h0})
		else $error("direct target wrong");
	a_local_first: assert property (@(posedge mclk) disable iff (rst)
		(irq_hit && |m_act[63:16]) |-> irq_code >= 6'(LOCAL_BASE))
		else $error("local interrupt lost priority");
	a_local_no_deleg: assert property (@(posedge mclk) disable iff (rst)
		mideleg_q[63:10] == '0 && !mideleg_q[0])
		else $error("local delegation bit set");
	a_deleg_copy: assert property (@(posedge mclk) disable iff (rst)
		(trap && deleg) |=> scause_q == $past(cause_val) &&
		sepc_q == $past(core_req.pc) && priv_q == PRIV_S)
		else $error("delegated trap state wrong");
	a_gate_off: assert property (@(posedge mclk) disable iff (rst)
		(priv_q == PRIV_M && !mstatus_q[ST_MIE]) |-> !irq_hit)
		else $error("interrupt taken while disabled");
endmodule

// >>> include/htc_pkg.sv
package htc_pkg;
	// register byte addresses on the apb slave
	localparam logic [7:0] ADDR_MSTATUS_LO = 8'h00;
	localparam logic [7:0] ADDR_MSTATUS_HI = 8'h04;
	localparam logic [7:0] ADDR_MIE_LO = 8'h08;
	localparam logic [7:0] ADDR_MIE_HI = 8'h0c;
	localparam logic [7:0] ADDR_MIP_LO = 8'h10;
	localparam logic [7:0] ADDR_MIP_HI = 8'h14;
	localparam logic [7:0] ADDR_MCAUSE_LO = 8'h18;
	localparam logic [7:0] ADDR_MCAUSE_HI = 8'h1c;
	localparam logic [7:0] ADDR_MTVEC_LO = 8'h20;
	localparam logic [7:0] ADDR_MTVEC_HI = 8'h24;
	localparam logic [7:0] ADDR_MIDELEG_LO = 8'h28;
	localparam logic [7:0] ADDR_MIDELEG_HI = 8'h2c;
	localparam logic [7:0] ADDR_MEDELEG_LO = 8'h30;
	localparam logic [7:0] ADDR_MEDELEG_HI = 8'h34;
	localparam logic [7:0] ADDR_SSTATUS_LO = 8'h38;
	localparam logic [7:0] ADDR_SSTATUS_HI = 8'h3c;
	localparam logic [7:0] ADDR_SCAUSE_LO = 8'h40;
	localparam logic [7:0] ADDR_SCAUSE_HI = 8'h44;
	localparam logic [7:0] ADDR_SEPC_LO = 8'h48;
	localparam logic [7:0] ADDR_SEPC_HI = 8'h4c;
	localparam logic [7:0] ADDR_MEPC_LO = 8'h50;
	localparam logic [7:0] ADDR_MEPC_HI = 8'h54;
	localparam logic [7:0] ADDR_STVEC_LO = 8'h58;
	localparam logic [7:0] ADDR_STVEC_HI = 8'h5c;
	localparam logic [7:0] ADDR_PRIV = 8'h60;
	// status field positions
	localparam int ST_SIE = 1;
	localparam int ST_MIE = 3;
	localparam int ST_SUPERVISOR_SAVED_IRQ_ON = 5;
	localparam int ST_MACHINE_SAVED_IRQ_ON = 7;
	localparam int ST_SPP = 8;
	localparam int ST_MPP_LO = 11;
	localparam int ST_MPP_HI = 12;
	// enable / pending positions
	localparam int IRQ_SS = 1;
	localparam int IRQ_MS = 3;
	localparam int IRQ_ST = 5;
	localparam int IRQ_MT = 7;
	localparam int IRQ_SE = 9;
	localparam int IRQ_ME = 11;
	localparam int LOCAL_BASE = 16;
	localparam int LOCAL_NUM = 48;
	localparam int CAUSE_IRQ_BIT = 63;
	// writable masks
	localparam logic [63:0] MSTATUS_MASK = 64'h0000_0000_0000_19aa;
	localparam logic [63:0] SSTATUS_MASK = 64'h0000_0000_0000_0122;
	localparam logic [63:0] MIE_MASK = 64'hffff_ffff_ffff_0aaa;
	localparam logic [63:0] MIP_SW_MASK = 64'h0000_0000_0000_0222;
	localparam logic [63:0] MIDELEG_MASK = 64'h0000_0000_0000_0222;
	localparam logic [63:0] MEDELEG_MASK = 64'h0000_0000_0000_b3ff;
	localparam logic [15:0] EXC_LEGAL = 16'hbbff;
	localparam logic [1:0] MODE_DIRECT = 2'h0;
	localparam logic [1:0] MODE_VECTORED = 2'h1;
	// reset values
	localparam logic [63:0] RST_ZERO = 64'h0;
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;
	localparam logic [1:0] RST_PRIV = 2'h3;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} htc_apb_req_s;

	typedef struct packed {
		logic exc_valid;
		logic [3:0] exc_code;
		logic ret_valid;
		logic [63:0] pc;
	} htc_core_req_s;

	typedef struct packed {
		logic redirect;
		logic [63:0] target;
		logic [1:0] priv;
	} htc_core_rsp_s;
endpackage

// >>> test/htc_core_model.sv
`timescale 1ns/100ps
// pipeline and interrupt sources: lines are levels, requests are pulses
module htc_core_model
	import htc_pkg::*;
(
	input wire logic mclk,
	input wire htc_core_rsp_s core_rsp,
	output htc_core_req_s core_req,
	output logic [47:0] local_irq,
	output logic [2:0] mach_irq
);
	int n_redir;
	htc_core_rsp_s last;
	initial
	begin
		core_req = '0;
		local_irq = '0;
		mach_irq = '0;
		n_redir = 0;
	end
	// redirect stands one cycle, so it is caught at that edge
	always @(posedge mclk)
		if (core_rsp.redirect === 1'b1)
		begin
			last <= core_rsp;
			n_redir <= n_redir + 1;
		end
	task pulse(input logic e, input logic [3:0] c, input logic r,
		input logic [63:0] p);
		@(posedge mclk);
		core_req <= '{e, c, r, p};
		@(posedge mclk);
		core_req.exc_valid <= 1'b0;
		core_req.ret_valid <= 1'b0;
	endtask
	task lines(input logic [47:0] l, input logic [2:0] m);
		@(posedge mclk);
		local_irq <= l;
		mach_irq <= m;
	endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/100ps
module testbench
	import htc_pkg::*;
;
	logic mclk = 0;
	logic rst = 1;
	htc_apb_req_s req = '0;
	logic pready, pslverr, perr;
	logic [31:0] prdata, lo;
	logic [63:0] v;
	logic [1:0] irq_taken, tk;
	htc_core_req_s core_req;
	htc_core_rsp_s core_rsp;
	logic [47:0] local_irq;
	logic [2:0] mach_irq;
	int n_errors = 0;
	int n_checks = 0;
	int k;
	logic [7:0] ta [6];
	logic [63:0] te [6];
	always #25 mclk = ~mclk;
	htc_trap_unit DUT (.mclk(mclk), .rst(rst), .apb_req(req),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.local_irq(local_irq), .machine_soft_irq_flag(mach_irq[0]),
		.machine_timer_irq_flag(mach_irq[1]),
		.machine_external_irq_flag(mach_irq[2]),
		.core_req(core_req), .core_rsp(core_rsp), .irq_taken(irq_taken));
	htc_core_model u_core (.mclk(mclk), .core_rsp(core_rsp),
		.core_req(core_req), .local_irq(local_irq), .mach_irq(mach_irq));
	always @(posedge mclk)
		if (irq_taken !== 2'b00)
			tk <= irq_taken;
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		lo = prdata;
		perr = pslverr;
		if (n >= 20)
			chk(1'b0, 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [63:0] d);
		apb(1'b1, a, d[31:0]);
		apb(1'b1, a + 8'h04, d[63:32]);
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		v[31:0] = lo;
		apb(1'b0, a + 8'h04, 32'h0);
		v[63:32] = lo;
	endtask
	// waits for the redirect count to reach n, bounded
	task wt(input int n);
		int i;
		for (i = 0; i < 30 && u_core.n_redir < n; i++)
			@(negedge mclk);
		chk(u_core.n_redir, n);
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#1000000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		ta = '{ADDR_MIE_LO, ADDR_MIDELEG_LO, ADDR_MEDELEG_LO, ADDR_MIP_LO,
			ADDR_MSTATUS_LO, ADDR_SSTATUS_LO};
		te = '{64'hffff_ffff_ffff_0aaa, 64'h222, 64'hb3ff, 64'h222,
			64'h19aa, 64'h122};
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rd(ADDR_MSTATUS_LO);
		chk(v, 64'h0);
		apb(1'b0, 8'h70, 32'h0);
		chk({perr, lo}, 33'h1_0000_0000);
		for (int i = 0; i < 6; i++)
		begin
			if (i == 4)
			begin
				wr(ADDR_MIP_LO, 64'h0);
				wr(ADDR_MIE_LO, 64'h0);
			end
			wr(ta[i], '1);
			rd(ta[i]);
			chk(v, te[i]);
		end
		chk(u_core.n_redir, 0);
		wr(ADDR_MSTATUS_LO, 64'h0);
		wr(ADDR_SSTATUS_LO, '1);
		rd(ADDR_MSTATUS_LO);
		chk(v, 64'h122);
		$display("test registers done");
		wr(ADDR_MTVEC_LO, 64'h1000);
		for (int c = 0; c < 16; c++)
		begin
			k = u_core.n_redir;
			u_core.pulse(1'b1, c[3:0], 1'b0, 64'h100 + c);
			repeat (4) @(negedge mclk);
			if (16'hbbff & (16'h1 << c))
			begin
				chk(u_core.n_redir, k + 1);
				chk(u_core.last.target, 64'h1000);
				rd(ADDR_MCAUSE_LO);
				chk(v, c);
				rd(ADDR_MEPC_LO);
				chk(v, 64'h100 + c);
			end
			else
				chk(u_core.n_redir, k);
		end
		$display("test exceptions done");
		wr(ADDR_MTVEC_LO, 64'h2001);
		wr(ADDR_MIE_LO, 64'h8000_0000_0001_0880);
		u_core.lines(48'h0, 3'b010);
		k = u_core.n_redir;
		repeat (10) @(negedge mclk);
		chk(u_core.n_redir, k);
		wr(ADDR_MSTATUS_LO, 64'h8);
		wt(k + 1);
		chk(u_core.last.target, 64'h201c);
		chk(tk, 2'b10);
		rd(ADDR_MCAUSE_LO);
		chk(v, 64'h8000_0000_0000_0007);
		rd(ADDR_MSTATUS_LO);
		chk(v, 64'h1880);
		u_core.lines(48'h0, 3'b000);
		u_core.pulse(1'b0, 4'h0, 1'b1, 64'h10f);
		wt(k + 2);
		chk(u_core.last.target, 64'h10f);
		rd(ADDR_MSTATUS_LO);
		chk(v, 64'h88);
		u_core.lines({1'b1, 46'h0, 1'b1}, 3'b100);
		wt(k + 3);
		chk(u_core.last.target, 64'h20fc);
		u_core.lines(48'h1, 3'b100);
		u_core.pulse(1'b0, 4'h0, 1'b1, 64'h10f);
		wt(k + 5);
		chk(u_core.last.target, 64'h2040);
		u_core.lines(48'h0, 3'b100);
		u_core.pulse(1'b0, 4'h0, 1'b1, 64'h10f);
		wt(k + 7);
		chk(u_core.last.target, 64'h202c);
		rd(ADDR_MCAUSE_LO);
		chk(v, 64'h8000_0000_0000_000b);
		u_core.lines(48'h0, 3'b000);
		$display("test interrupts done");
		wr(ADDR_STVEC_LO, 64'h3000);
		wr(ADDR_MEDELEG_LO, 64'h200);
		wr(ADDR_MIDELEG_LO, '1);
		wr(ADDR_MSTATUS_LO, 64'h808);
		k = u_core.n_redir;
		u_core.pulse(1'b0, 4'h0, 1'b1, 64'h10f);
		wt(k + 1);
		apb(1'b0, ADDR_PRIV, 32'h0);
		chk(lo, 32'h1);
		u_core.pulse(1'b1, 4'h9, 1'b0, 64'h500);
		wt(k + 2);
		chk({u_core.last.target, u_core.last.priv}, {64'h3000, 2'h1});
		rd(ADDR_SCAUSE_LO);
		chk(v, 64'h9);
		rd(ADDR_SEPC_LO);
		chk(v, 64'h500);
		u_core.lines(48'h1, 3'b000);
		wt(k + 3);
		chk({u_core.last.target, u_core.last.priv}, {64'h2040, 2'h3});
		chk(tk, 2'b10);
		u_core.lines(48'h0, 3'b000);
		u_core.pulse(1'b0, 4'h0, 1'b1, 64'h10f);
		wt(k + 4);
		wr(ADDR_MIE_LO, 64'h8000_0000_0001_0882);
		wr(ADDR_SSTATUS_LO, 64'h2);
		wr(ADDR_MIP_LO, 64'h2);
		wt(k + 5);
		chk({u_core.last.target, u_core.last.priv}, {64'h3000, 2'h1});
		chk(tk, 2'b01);
		rd(ADDR_SCAUSE_LO);
		chk(v, 64'h8000_0000_0000_0001);
		$display("test delegation done");
		print_verdict();
	end
endmodule
